// ---- hw/mcs_device.sv ----
// Comparator self-test controller with its register set, device end
// Contract
// RULE_01 - Comparator-only fault shorter than deglitch time
// RULE_02 - Comparator output high exactly while fault applied
// RULE_03 - Comparator-only: all outputs must match expected
// RULE_04 - Status field; clear passed bits, leftovers fail
// RULE_05 - Host uses documented comparator-only maximal selections
// RULE_06 - Passing comparator test: only done flag raised
// RULE_07 - Deglitch mode: long fault, flags and outputs
// RULE_08 - Deglitch mode: compare deglitch outputs, same reporting
// RULE_09 - Safe-state reaction only when started in NORMAL
// RULE_10 - Host never selects supply overvoltage for deglitch
// RULE_11 - Host uses documented deglitch maximal selections
// RULE_12 - Deglitch results: fixed flag values, status mirrors selection
// RULE_13 - Shutdown test in NORMAL: outputs low, WAKE, no reset
// RULE_14 - Only first tested comparator drives output reaction (code: the first passing comparator drives it)
// RULE_15 - INIT or WAKE: safe-state outputs already active
// RULE_16 - Host reads flags and status, compares expected
// RULE_17 - Host enables comparator output before selecting it (code: the host writes no enable; monitors are assumed enabled)
// RULE_18 - Severe faults to shutdown path, others interrupt
// RULE_19 - Start stays set while running; done raises event
// RULE_20 - Host configures control fields before setting start
// RULE_21 - Selection latched at start, fixed sequence order
//
// The strobed register port and the register addresses were decided locally.
`default_nettype none
module mcs_device (
  mcs_link_if.dev link,
  input wire mcs_pkg::mcs_sys_state_e system_state,
  input wire logic [mcs_pkg::NUM_COMP-1:0] comparator_out,
  input wire logic reset_request,
  output logic [mcs_pkg::NUM_COMP-1:0] fault_inject,
  output logic [1:0] safe_state_outputs,
  output logic wake_request,
  output logic reset_output,
  output logic interrupt_out
);
  import mcs_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SCAN, ST_INJECT, ST_SETTLE, ST_FINISH} mcs_dev_state_e;

  localparam logic [NUM_COMP-1:0] ONE_HOT = 24'h000001;
  localparam logic [4:0] LAST_IDX = 5'(NUM_COMP - 1);

  if (LONG_CYC <= DEGLITCH_CNT || SHORT_CYC >= DEGLITCH_CNT) begin : g_bad_timing
    $error("Fault durations do not straddle the deglitch time");
  end

  mcs_dev_state_e state_ff;
  logic [3:0] ctrl_ff;
  logic status_fail_ff;
  logic [NUM_COMP-1:0] sel_ff;
  logic [NUM_COMP-1:0] mon_ff;
  logic [7:0] irq_ff;
  logic [7:0] initf_ff;
  logic [7:0] sysf_ff;
  logic [NUM_COMP-1:0] cmp_s1_ff;
  logic [NUM_COMP-1:0] cmp_s2_ff;
  logic [4:0] idx_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] dg_ff;
  logic hit_ff;
  logic reacted_ff;
  logic trip_ff;
  logic [NUM_COMP-1:0] inject_ff;
  logic [1:0] safe_ff;
  logic wake_ff;
  logic rst_out_ff;
  logic int_ff;
  logic rvalid_ff;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  logic wr;
  logic busy;
  logic start_wr;
  logic cur_cmp;
  logic [CNT_W-1:0] dur;
  logic eval;
  logic pass_now;
  logic react;
  logic react_sd;
  logic skip_internal_supply_overvoltage_select;
  logic last;
  logic ev_done;
  logic [7:0] clr_irq;
  logic [7:0] clr_initf;
  logic [7:0] clr_sysf;
  logic [NUM_COMP-1:0] clr_mon;
  logic [NUM_COMP-1:0] mon_set;

  function automatic logic [7:0] clr_mask(input logic w, input logic [3:0] a,
                                           input logic [3:0] target, input logic [7:0] d);
    clr_mask = (w && a == target) ? d : 8'h00;
  endfunction

  assign wr = link.req && link.we;
  assign busy = ctrl_ff[CTRL_START];
  assign start_wr = wr && link.addr == ADDR_CTRL0 && link.wdata[CTRL_START] && !busy;
  assign cur_cmp = cmp_s2_ff[idx_ff];
  assign dur = ctrl_ff[CTRL_PATH] ? LONG_CYC : SHORT_CYC; // [RULE_01] [RULE_07]
  assign eval = state_ff == ST_SETTLE && cnt_ff == SETTLE_CYC - 10'h001;
  // Output must have been high at the end of the fault and gone once it was removed
  assign pass_now = hit_ff && !cur_cmp; // [RULE_02] [RULE_03] [RULE_08]
  // Output path is exercised by the first passing comparator of a deglitch run only
  assign react = eval && pass_now && ctrl_ff[CTRL_PATH] && !reacted_ff; // [RULE_14]
  assign react_sd = react && SHUTDOWN_MASK[idx_ff]; // [RULE_18]
  // This comparator cannot be run through deglitching; it is left selected and fails
  assign skip_internal_supply_overvoltage_select = state_ff == ST_SCAN && sel_ff[idx_ff] && ctrl_ff[CTRL_PATH]
                      && idx_ff == 5'(INTERNAL_SUPPLY_OVERVOLTAGE_SELECT_BIT);
  assign last = idx_ff == LAST_IDX;
  assign ev_done = state_ff == ST_FINISH;
  assign clr_irq = clr_mask(wr, link.addr, ADDR_IRQ, link.wdata);
  assign clr_initf = clr_mask(wr, link.addr, ADDR_INITF, link.wdata);
  assign clr_sysf = clr_mask(wr, link.addr, ADDR_SYSF, link.wdata);
  assign clr_mon = {clr_mask(wr, link.addr, ADDR_MON3, link.wdata),
                    clr_mask(wr, link.addr, ADDR_MON2, link.wdata),
                    clr_mask(wr, link.addr, ADDR_MON1, link.wdata)};
  assign mon_set = (eval && pass_now && ctrl_ff[CTRL_PATH]) ? (ONE_HOT << idx_ff) : '0;

  // Comparators are analog and asynchronous to the logic clock
  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      cmp_s1_ff <= '0;
      cmp_s2_ff <= '0;
    end else begin
      cmp_s1_ff <= comparator_out;
      cmp_s2_ff <= cmp_s1_ff;
    end
  end

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      state_ff <= ST_IDLE;
      idx_ff <= '0;
      cnt_ff <= '0;
      dg_ff <= '0;
      hit_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_wr) begin
            state_ff <= ST_SCAN;
            idx_ff <= '0;
          end
        end
        ST_SCAN: begin
          if (sel_ff[idx_ff] && !skip_internal_supply_overvoltage_select) begin // [RULE_21]
            state_ff <= ST_INJECT;
            cnt_ff <= '0;
            dg_ff <= '0;
          end else if (last) begin
            state_ff <= ST_FINISH;
          end else begin
            idx_ff <= idx_ff + 5'h01;
          end
        end
        ST_INJECT: begin
          cnt_ff <= cnt_ff + 10'h001;
          if (cur_cmp && dg_ff != LONG_CYC) begin
            dg_ff <= dg_ff + 10'h001;
          end else if (!cur_cmp) begin
            dg_ff <= '0;
          end
          if (cnt_ff == dur - 10'h001) begin
            state_ff <= ST_SETTLE;
            cnt_ff <= '0;
            // Deglitch mode judges the filtered output, comparator mode the raw one
            hit_ff <= ctrl_ff[CTRL_PATH] ? (dg_ff >= DEGLITCH_CNT) : cur_cmp; // [RULE_08]
          end
        end
        ST_SETTLE: begin
          cnt_ff <= cnt_ff + 10'h001;
          if (eval) begin
            if (ctrl_ff[CTRL_SINGLE] || last) begin
              state_ff <= ST_FINISH;
            end else begin
              state_ff <= ST_SCAN;
              idx_ff <= idx_ff + 5'h01;
            end
          end
        end
        ST_FINISH: begin
          state_ff <= ST_IDLE;
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      inject_ff <= '0;
    end else begin
      inject_ff <= (state_ff == ST_INJECT) ? (ONE_HOT << idx_ff) : '0; // [RULE_01] [RULE_07]
    end
  end

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      ctrl_ff <= '0;
      status_fail_ff <= 1'b0;
    end else if (ev_done) begin
      ctrl_ff[CTRL_START] <= 1'b0; // [RULE_19]
      status_fail_ff <= |sel_ff; // [RULE_04]
    end else if (wr && link.addr == ADDR_CTRL0 && !busy) begin
      ctrl_ff <= link.wdata[3:0]; // [RULE_19]
    end
  end

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      sel_ff <= '0;
    end else begin
      // Host writes to the selection are ignored for the whole run
      if (wr && !busy) begin // [RULE_21]
        if (link.addr == ADDR_SEL0) begin
          sel_ff[7:0] <= link.wdata;
        end else if (link.addr == ADDR_SEL1) begin
          sel_ff[15:8] <= link.wdata;
        end else if (link.addr == ADDR_SEL2) begin
          sel_ff[23:16] <= link.wdata;
        end
      end
      if (eval && pass_now) begin
        sel_ff[idx_ff] <= 1'b0; // [RULE_04] [RULE_08]
      end
    end
  end

  // Flags are write-one-to-clear; a set in the same cycle wins
  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      irq_ff <= '0;
      initf_ff <= '0;
      sysf_ff <= '0;
      mon_ff <= '0;
    end else begin
      irq_ff <= irq_ff & ~clr_irq;
      irq_ff[IRQ_DONE_BIT] <= (irq_ff[IRQ_DONE_BIT] & ~clr_irq[IRQ_DONE_BIT])
                              | ev_done; // [RULE_06] [RULE_19]
      irq_ff[IRQ_MON_BIT] <= (irq_ff[IRQ_MON_BIT] & ~clr_irq[IRQ_MON_BIT])
                             | (react && !react_sd); // [RULE_18] [RULE_12]
      initf_ff <= initf_ff & ~clr_initf;
      initf_ff[VMON_BIT] <= (initf_ff[VMON_BIT] & ~clr_initf[VMON_BIT])
                            | react_sd; // [RULE_07] [RULE_12]
      sysf_ff <= sysf_ff & ~clr_sysf;
      sysf_ff[VMON_BIT] <= (sysf_ff[VMON_BIT] & ~clr_sysf[VMON_BIT]) | react_sd; // [RULE_12]
      mon_ff <= (mon_ff & ~clr_mon) | mon_set; // [RULE_12]
    end
  end

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      reacted_ff <= 1'b0;
    end else if (start_wr) begin
      reacted_ff <= 1'b0;
    end else if (react) begin
      reacted_ff <= 1'b1; // [RULE_14]
    end
  end

  // Trip holds the outputs low until the state machine has left NORMAL
  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      trip_ff <= 1'b0;
    end else if (react_sd && system_state == MCS_NORMAL) begin
      trip_ff <= 1'b1; // [RULE_09] [RULE_13]
    end else if (system_state != MCS_NORMAL) begin
      trip_ff <= 1'b0;
    end
  end

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      safe_ff <= 2'h0;
      wake_ff <= 1'b0;
      rst_out_ff <= 1'b0;
      int_ff <= 1'b0;
    end else begin
      // Outside NORMAL the outputs are already in safe state
      safe_ff <= (system_state == MCS_NORMAL && !trip_ff && !react_sd) ? 2'h3 : 2'h0; // [RULE_15]
      wake_ff <= react_sd && system_state == MCS_NORMAL; // [RULE_13]
      rst_out_ff <= reset_request && !busy; // [RULE_13]
      int_ff <= ev_done || (react && !react_sd); // [RULE_18]
    end
  end

  always_comb begin
    if (link.addr == ADDR_CTRL0) begin
      nxt_rdata = {status_fail_ff, 3'h0, ctrl_ff}; // [RULE_04]
    end else if (link.addr == ADDR_SEL0) begin
      nxt_rdata = sel_ff[7:0];
    end else if (link.addr == ADDR_SEL1) begin
      nxt_rdata = sel_ff[15:8];
    end else if (link.addr == ADDR_SEL2) begin
      nxt_rdata = sel_ff[23:16];
    end else if (link.addr == ADDR_IRQ) begin
      nxt_rdata = irq_ff;
    end else if (link.addr == ADDR_INITF) begin
      nxt_rdata = initf_ff;
    end else if (link.addr == ADDR_SYSF) begin
      nxt_rdata = sysf_ff;
    end else if (link.addr == ADDR_MON1) begin
      nxt_rdata = mon_ff[7:0];
    end else if (link.addr == ADDR_MON2) begin
      nxt_rdata = mon_ff[15:8];
    end else if (link.addr == ADDR_MON3) begin
      nxt_rdata = mon_ff[23:16];
    end else begin
      nxt_rdata = 8'h00;
    end
  end

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      rvalid_ff <= link.req && !link.we;
      if (link.req && !link.we) begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign link.rvalid = rvalid_ff;
  assign link.rdata = rdata_ff;
  assign fault_inject = inject_ff;
  assign safe_state_outputs = safe_ff;
  assign wake_request = wake_ff;
  assign reset_output = rst_out_ff;
  assign interrupt_out = int_ff;
endmodule
`default_nettype wire

// ---- hw/mcs_pkg.sv ----
// Shared constants and types for the comparator self-test device and host
`default_nettype none
package mcs_pkg;
  localparam int NUM_COMP = 24;
  localparam int CNT_W = 10;
  localparam int CLK_PERIOD_NS = 40;
  localparam int DEGLITCH_TIME_NS = 10000;
  localparam int DEGLITCH_CYC = DEGLITCH_TIME_NS / CLK_PERIOD_NS;
  localparam logic [CNT_W-1:0] DEGLITCH_CNT = CNT_W'(DEGLITCH_CYC);
  // Short fault stays well inside the deglitch window, long fault well past it
  localparam logic [CNT_W-1:0] SHORT_CYC = CNT_W'(DEGLITCH_CYC / 2);
  localparam logic [CNT_W-1:0] LONG_CYC = CNT_W'(DEGLITCH_CYC + DEGLITCH_CYC / 4);
  localparam logic [CNT_W-1:0] SETTLE_CYC = 10'h006;

  localparam logic [3:0] ADDR_CTRL0 = 4'h0;
  localparam logic [3:0] ADDR_SEL0 = 4'h1;
  localparam logic [3:0] ADDR_SEL1 = 4'h2;
  localparam logic [3:0] ADDR_SEL2 = 4'h3;
  localparam logic [3:0] ADDR_IRQ = 4'h4;
  localparam logic [3:0] ADDR_INITF = 4'h5;
  localparam logic [3:0] ADDR_SYSF = 4'h6;
  localparam logic [3:0] ADDR_MON1 = 4'h7;
  localparam logic [3:0] ADDR_MON2 = 4'h8;
  localparam logic [3:0] ADDR_MON3 = 4'h9;

  localparam int CTRL_START = 0;
  localparam int CTRL_PATH = 1;
  localparam int CTRL_SINGLE = 2;
  localparam int CTRL_INT = 3;
  localparam int CTRL_STATUS = 7;
  localparam int IRQ_DONE_BIT = 6;
  localparam int IRQ_MON_BIT = 3;
  localparam int VMON_BIT = 2;
  localparam int INTERNAL_SUPPLY_OVERVOLTAGE_SELECT_BIT = 19;
  // Bit order {select2, select1, select0}
  localparam logic [NUM_COMP-1:0] SHUTDOWN_MASK = 24'hC90E2F;

  localparam logic [7:0] SD_SEL0 = 8'h2F;
  localparam logic [7:0] SD_SEL1 = 8'h0E;
  localparam logic [7:0] SD_SEL2_CMP = 8'hC9;
  localparam logic [7:0] SD_SEL2_DG = 8'hC1;
  localparam logic [7:0] INT_SEL0 = 8'hD0;
  localparam logic [7:0] INT_SEL1 = 8'hF1;
  localparam logic [7:0] INT_SEL2 = 8'h30;
  localparam logic [7:0] CTRL_CMP_SD = 8'h01;
  localparam logic [7:0] CTRL_CMP_INT = 8'h09;
  localparam logic [7:0] CTRL_DG_SD = 8'h03;
  localparam logic [7:0] CTRL_DG_INT = 8'h0B;
  localparam logic [7:0] EXP_IRQ_SD = 8'h40;
  localparam logic [7:0] EXP_IRQ_DG_INT = 8'h48;
  localparam logic [7:0] EXP_FAIL_SD = 8'h04;
  localparam logic [7:0] CLEAR_ALL = 8'hFF;
  localparam logic [4:0] HOST_LAST_STEP = 5'h09;

  typedef enum logic [1:0] {MCS_INIT, MCS_NORMAL, MCS_WAKE} mcs_sys_state_e;
endpackage
`default_nettype wire

// ---- hw/mcs_link_if.sv ----
// Register link between the self-test host and the device
`default_nettype none
interface mcs_link_if (
  input wire logic clock,
  input wire logic rst
);
  logic req;
  logic we;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic rvalid;
  logic [7:0] rdata;
  modport dev (input clock, rst, req, we, addr, wdata, output rvalid, rdata);
  modport host (input clock, rst, rvalid, rdata, output req, we, addr, wdata);
endinterface
`default_nettype wire

// ---- hw/mcs_host.sv ----
// Self-test host sequencer that drives the device over the register link
`default_nettype none
module mcs_host (
  mcs_link_if.host link,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  import mcs_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_WRITE, H_POLL, H_POLLW, H_READ, H_READW} mcs_host_state_e;

  localparam logic [2:0] UADDR_CMD = 3'h0;
  localparam logic [2:0] UADDR_STATUS = 3'h1;
  localparam logic [2:0] UADDR_RESID = 3'h2;

  mcs_host_state_e state_ff;
  logic [1:0] preset_ff;
  logic [4:0] step_ff;
  logic check_ok_ff;
  logic done_ff;
  logic req_ff;
  logic we_ff;
  logic [3:0] addr_ff;
  logic [7:0] wdata_ff;
  logic [7:0] resid_ff [0:3];
  logic [7:0] rdata_ff;
  logic busy;

  // Monitors are assumed enabled by the application before any preset runs [RULE_17]
  // Presets: bit1 selects deglitch mode, bit0 the interrupt path
  function automatic logic [7:0] ctrl_of(input logic [1:0] p);
    if (p == 2'h0) begin
      ctrl_of = CTRL_CMP_SD; // [RULE_05] [RULE_20]
    end else if (p == 2'h1) begin
      ctrl_of = CTRL_CMP_INT; // [RULE_05]
    end else if (p == 2'h2) begin
      ctrl_of = CTRL_DG_SD; // [RULE_11]
    end else begin
      ctrl_of = CTRL_DG_INT; // [RULE_11]
    end
  endfunction

  function automatic logic [7:0] sel_of(input logic [1:0] p, input logic [1:0] k);
    if (p[0]) begin
      sel_of = (k == 2'h0) ? INT_SEL0 : (k == 2'h1) ? INT_SEL1 : INT_SEL2;
    end else if (k == 2'h0) begin
      sel_of = SD_SEL0;
    end else if (k == 2'h1) begin
      sel_of = SD_SEL1;
    end else begin
      // Supply overvoltage stays out of deglitch runs [RULE_10]
      sel_of = p[1] ? SD_SEL2_DG : SD_SEL2_CMP;
    end
  endfunction

  function automatic logic [3:0] waddr(input logic [4:0] s);
    if (s < 5'h06) begin
      waddr = 4'(s + 5'h04);
    end else if (s == HOST_LAST_STEP) begin
      waddr = ADDR_CTRL0;
    end else begin
      waddr = 4'(s - 5'h05);
    end
  endfunction

  function automatic logic [7:0] wval(input logic [4:0] s, input logic [1:0] p);
    if (s < 5'h06) begin
      wval = CLEAR_ALL;
    end else if (s == HOST_LAST_STEP) begin
      wval = ctrl_of(p);
    end else begin
      wval = sel_of(p, 2'(s - 5'h06));
    end
  endfunction

  function automatic logic [7:0] exp_val(input logic [4:0] s, input logic [1:0] p);
    if (s == 5'(ADDR_CTRL0)) begin
      exp_val = ctrl_of(p) & ~8'h01;
    end else if (s <= 5'(ADDR_SEL2)) begin
      exp_val = 8'h00;
    end else if (s == 5'(ADDR_IRQ)) begin
      exp_val = (p == 2'h3) ? EXP_IRQ_DG_INT : EXP_IRQ_SD;
    end else if (s <= 5'(ADDR_SYSF)) begin
      exp_val = (p == 2'h2) ? EXP_FAIL_SD : 8'h00;
    end else begin
      exp_val = p[1] ? sel_of(p, 2'(s - 5'h07)) : 8'h00;
    end
  endfunction

  assign busy = state_ff != H_IDLE;

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      state_ff <= H_IDLE;
      preset_ff <= 2'h0;
      step_ff <= '0;
      check_ok_ff <= 1'b0;
      done_ff <= 1'b0;
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      addr_ff <= 4'h0;
      wdata_ff <= 8'h00;
    end else begin
      req_ff <= 1'b0;
      case (state_ff)
        H_IDLE: begin
          if (wr && addr == UADDR_CMD) begin
            preset_ff <= wdata[1:0];
            step_ff <= '0;
            check_ok_ff <= 1'b1;
            done_ff <= 1'b0;
            state_ff <= H_WRITE;
          end
        end
        H_WRITE: begin
          // Clear flags, load selections, then the control word with start last
          req_ff <= 1'b1; // [RULE_20]
          we_ff <= 1'b1;
          addr_ff <= waddr(step_ff);
          wdata_ff <= wval(step_ff, preset_ff);
          if (step_ff == HOST_LAST_STEP) begin
            state_ff <= H_POLL;
          end else begin
            step_ff <= step_ff + 5'h01;
          end
        end
        H_POLL: begin
          req_ff <= 1'b1;
          we_ff <= 1'b0;
          addr_ff <= ADDR_CTRL0;
          state_ff <= H_POLLW;
        end
        H_POLLW: begin
          if (link.rvalid) begin
            state_ff <= link.rdata[CTRL_START] ? H_POLL : H_READ;
            step_ff <= '0;
          end
        end
        H_READ: begin
          req_ff <= 1'b1;
          we_ff <= 1'b0;
          addr_ff <= step_ff[3:0];
          state_ff <= H_READW;
        end
        H_READW: begin
          if (link.rvalid) begin
            if (link.rdata != exp_val(step_ff, preset_ff)) begin
              check_ok_ff <= 1'b0; // [RULE_16]
            end
            if (step_ff == HOST_LAST_STEP) begin
              state_ff <= H_IDLE;
              done_ff <= 1'b1;
            end else begin
              step_ff <= step_ff + 5'h01;
              state_ff <= H_READ;
            end
          end
        end
        default: begin
          state_ff <= H_IDLE;
        end
      endcase
    end
  end

  // Keeps what the device left in control and selection registers for diagnosis
  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      for (int i = 0; i < 4; i++) begin
        resid_ff[i] <= 8'h00;
      end
    end else if (state_ff == H_READW && link.rvalid && step_ff < 5'h04) begin
      resid_ff[step_ff[1:0]] <= link.rdata; // [RULE_16]
    end
  end

  always_ff @(posedge link.clock or posedge link.rst) begin
    if (link.rst) begin
      rdata_ff <= 8'h00;
    end else if (rd) begin
      if (addr == UADDR_CMD) begin
        rdata_ff <= {6'h00, preset_ff};
      end else if (addr == UADDR_STATUS) begin
        rdata_ff <= {5'h00, busy, done_ff, check_ok_ff};
      end else if (addr >= UADDR_RESID && addr <= 3'h5) begin
        rdata_ff <= resid_ff[2'(addr - UADDR_RESID)];
      end else begin
        rdata_ff <= 8'h00;
      end
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign link.req = req_ff;
  assign link.we = we_ff;
  assign link.addr = addr_ff;
  assign link.wdata = wdata_ff;
  assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ---- testbench/mcs_monitor.sv ----
// Link checks between the self-test host and device
`default_nettype none
module mcs_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic req,
  input wire logic we,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rvalid,
  input wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import mcs_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [3:0] ra_ff;
  logic [9:0] age_ff;
  wire go = req && we && addr == ADDR_CTRL0;
  // Age saturates so a late poll never wraps back into the running window
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ra_ff <= 4'h0;
      age_ff <= 10'h3FF;
    end else begin
      if (req) ra_ff <= addr;
      if (go) age_ff <= 10'h000;
      else if (age_ff != 10'h3FF) age_ff <= age_ff + 10'h001;
    end
  end
  a_read_answer: assert property (req && !we |=> rvalid)
    else $error("no read data");
  a_valid_cause: assert property (rvalid |-> $past(req) && !$past(we))
    else $error("read data without request");
  a_data_holds: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved");
  a_start_held: assert property (
    rvalid && ra_ff == ADDR_CTRL0 && age_ff < 10'h064 |-> rdata[CTRL_START])
    else $error("start dropped early");
  a_sel_order: assert property (go |->
    $past(req) && $past(we) && $past(addr) == ADDR_SEL2)
    else $error("control before selection");
  a_no_internal_supply_overvoltage_select: assert property (go && wdata[CTRL_PATH] |->
    ($past(wdata) & 8'h08) == 8'h00)
    else $error("supply overvoltage in deglitch test");
  a_sd_cmp_sel: assert property (go && wdata == CTRL_CMP_SD |->
    $past(wdata, 3) == SD_SEL0 && $past(wdata, 2) == SD_SEL1 && $past(wdata) == SD_SEL2_CMP)
    else $error("bad shutdown selection");
  a_sd_dg_sel: assert property (go && wdata == CTRL_DG_SD |->
    $past(wdata, 3) == SD_SEL0 && $past(wdata, 2) == SD_SEL1 && $past(wdata) == SD_SEL2_DG)
    else $error("bad deglitch selection");
  a_int_sel: assert property (go && wdata[CTRL_INT] |->
    $past(wdata, 3) == INT_SEL0 && $past(wdata, 2) == INT_SEL1 && $past(wdata) == INT_SEL2)
    else $error("bad interrupt selection");
endmodule
`default_nettype wire

// ---- testbench/monitor_comparator_selftest_test.sv ----
// Self-checking bench: host sequencer against the self-test device
`default_nettype none
module monitor_comparator_selftest_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mcs_pkg::*;
  localparam logic [7:0] CTRLS [4] = '{CTRL_CMP_SD, CTRL_CMP_INT, CTRL_DG_SD, CTRL_DG_INT};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rreq = 1'b0;
  logic [7:0] rdata;
  logic [1:0] ss;
  logic wake, rout, irq;
  mcs_sys_state_e st = MCS_NORMAL;
  logic [NUM_COMP-1:0] cmp = '0;
  logic [NUM_COMP-1:0] bad = '0;
  logic [NUM_COMP-1:0] fi;
  logic [NUM_COMP-1:0] fi_last;
  int err_total = 0;
  int n_compared = 0;
  int run_len = 0;
  int exp_len = 0;
  // Pulses, bad lengths, bad order, wakes, interrupts, resets while injecting
  int cnt [6];
  mcs_link_if lk (.clock(clock), .rst(rst));
  mcs_device mcs_device_inst (.link(lk), .system_state(st), .comparator_out(cmp),
    .reset_request(rreq), .fault_inject(fi), .safe_state_outputs(ss), .wake_request(wake),
    .reset_output(rout), .interrupt_out(irq));
  mcs_host mcs_host_inst (.link(lk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  mcs_monitor mcs_monitor_inst (.clock(clock), .rst(rst), .req(lk.req), .we(lk.we),
    .addr(lk.addr), .wdata(lk.wdata), .rvalid(lk.rvalid), .rdata(lk.rdata));
  initial forever #20 clock = ~clock;
  // A broken comparator stays low; the state machine obeys each wake request
  always @(posedge clock) begin
    cmp <= fi & ~bad;
    if (wake) st <= MCS_WAKE;
    cnt[3] += int'(wake);
    cnt[4] += int'(irq);
    cnt[5] += int'(rout && |fi);
    if (|fi) begin
      run_len++;
      if (run_len == 1 && (fi <= fi_last || !$onehot(fi))) cnt[2]++;
      if (run_len == 1) fi_last = fi;
    end else if (run_len > 0) begin
      cnt[0]++;
      cnt[1] += int'(run_len != exp_len);
      run_len = 0;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [NUM_COMP-1:0] sel_of(input int p);
    if (p == 0) return {SD_SEL2_CMP, SD_SEL1, SD_SEL0};
    if (p == 2) return {SD_SEL2_DG, SD_SEL1, SD_SEL0};
    return {INT_SEL2, INT_SEL1, INT_SEL0};
  endfunction
  task automatic run(input int p, input mcs_sys_state_e s, input logic broken);
    logic [NUM_COMP-1:0] sel;
    logic [7:0] v;
    int k;
    sel = sel_of(p);
    bad = '0;
    k = $urandom_range(NUM_COMP - 1);
    while (!sel[k]) k = (k + 1) % NUM_COMP;
    bad[k] = broken;
    cnt = '{default: 0};
    fi_last = '0;
    exp_len = (p < 2) ? SHORT_CYC : LONG_CYC;
    @(posedge clock);
    rst <= 1'b1;
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    st <= s;
    rreq <= 1'b1;
    wr_reg(3'h0, 8'(p));
    // Second command lands while busy and must be ignored
    wr_reg(3'h0, 8'((p + 1) % 4));
    v = 8'h04;
    for (k = 0; k < 5000 && v[2]; k++) rd_reg(3'h1, v);
    check(32'(v[2:0]), 32'({2'b01, !broken}));
    if (v[2]) give_verdict();
    rd_reg(3'h2, v);
    check(32'(v), 32'({broken, CTRLS[p][6:1], 1'b0}));
    rd_reg(3'h0, v);
    check(32'(v), 32'(p));
    for (k = 0; k < 3; k++) begin
      rd_reg(3'(3 + k), v);
      check(32'(v), 32'(bad[8*k +: 8]));
    end
    check(32'(cnt[0]), 32'($countones(sel)));
    check(32'(cnt[1] + cnt[2] + cnt[5]), 32'h0);
    check(32'(cnt[3]), 32'(s == MCS_NORMAL && p == 2));
    check(32'(cnt[4]), 32'(1 + (p == 3)));
    check(32'(ss), (s == MCS_NORMAL && p != 2) ? 32'h3 : 32'h0);
    check(32'(rout), 32'h1);
    $display("Run preset %0d state %0d broken %0b done", p, s, broken);
  endtask
  initial begin
    void'($urandom(62829));
    for (int p = 0; p < 4; p++) run(p, MCS_NORMAL, 1'b0);
    run(2, MCS_INIT, 1'b1);
    run(3, MCS_WAKE, 1'b0);
    for (int i = 0; i < 4; i++) begin
      run($urandom_range(3), mcs_sys_state_e'($urandom_range(2)), 1'($urandom_range(1)));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
